// >>> shared/twm_map.svh
// Purpose: constants of the two-wire master engine
// Assumes: included by its bare name
// Notes:   field positions index the flag and enable vectors
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// ****************************************
// widths and counts
// ****************************************
`define TWM_ADDR_W     7
`define TWM_DIV_W      8
`define TWM_EXP_W      3
`define TWM_CNT_W      16
`define TWM_BIT_W      4
`define TWM_FIFO_DEPTH 16
`define TWM_LAST_BIT   4'h7
`define TWM_ACK_BIT    4'h8
`define TWM_MIN_TICKS  16'h0002

// ****************************************
// flag and enable positions
// ****************************************
`define TWM_FLG_TRANSMIT_READY_FLAG  0
`define TWM_FLG_RECEIVE_READY_FLAG  1
`define TWM_FLG_NOT_ACKNOWLEDGED_FLAG   2
`define TWM_FLG_W      3

`endif

// >>> shared/twm_pkg.sv
// Purpose: types of the two-wire master engine
// Assumes: nothing
// Notes:   states and byte phases only
package twm_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_START_HOLD,
		ST_BIT_LOW,
		ST_BIT_HIGH,
		ST_WAIT_TX,
		ST_RS_LOW,
		ST_RS_HIGH,
		ST_STOP_LOW,
		ST_STOP_HIGH,
		ST_STOP_REL
	} twm_state_e;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_INTERNAL_ADDRESS_BYTES,
		PH_WDATA,
		PH_RDATA
	} twm_phase_e;

endpackage : twm_pkg

// >>> design/twm_master.sv
// Purpose: master engine of a two-wire serial interface with transmit FIFO
// Assumes: open-drain pins resolved outside; control bits from same clock
// Notes:   control and status are plain ports, no register bus
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"

// ****************************************
// transmit FIFO
// ****************************************
module twm_fifo #(
	parameter int W = 8,
	parameter int D = `TWM_FIFO_DEPTH
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(D);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   cnt_d;
	logic          push;
	logic          pop;

	assign push = in_valid_i & in_ready_o;
	assign pop = out_ready_i & out_valid_o;
	assign out_data_o = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push & ~pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop & ~push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q        <= '0;
			rd_q        <= '0;
			cnt_q       <= '0;
			in_ready_o  <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q       <= cnt_d;
			in_ready_o  <= (cnt_d != FULL);
			out_valid_o <= (cnt_d != '0);
		end
	end
endmodule : twm_fifo

// ****************************************
// master engine
// ****************************************
module twm_master (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  master_enable_cmd_i,
	input  wire logic                  slave_disable_cmd_i,
	input  wire logic [`TWM_ADDR_W-1:0] target_device_address_i,
	input  wire logic                  read_direction_i,
	input  wire logic [1:0]            internal_address_size_i,
	input  wire logic [23:0]           internal_address_bytes_i,
	input  wire logic [`TWM_EXP_W-1:0] clock_exponent_divider_i,
	input  wire logic [`TWM_DIV_W-1:0] clock_high_divider_i,
	input  wire logic [`TWM_DIV_W-1:0] clock_low_divider_i,
	input  wire logic                  start_cmd_i,
	input  wire logic                  stop_cmd_i,
	input  wire logic [7:0]            tx_data_i,
	input  wire logic                  tx_valid_i,
	output logic                       tx_ready_o,
	input  wire logic                  rx_read_i,
	output logic [7:0]                 rx_data_o,
	input  wire logic                  status_read_i,
	input  wire logic [`TWM_FLG_W-1:0] int_enable_i,
	output logic                       transmit_ready_flag_o,
	output logic                       receive_ready_flag_o,
	output logic                       not_acknowledged_flag_o,
	output logic                       irq_o,
	input  wire logic                  serial_clock_line_i,
	output logic                       serial_clock_line_o,
	output logic                       serial_clock_line_oe_o,
	input  wire logic                  serial_data_line_i,
	output logic                       serial_data_line_o,
	output logic                       serial_data_line_oe_o
);
	twm_pkg::twm_state_e       st_q;
	twm_pkg::twm_phase_e       ph_q;
	logic [`TWM_CNT_W-1:0]     cnt_q;
	logic [`TWM_CNT_W-1:0]     lo_ticks;
	logic [`TWM_CNT_W-1:0]     hi_ticks;
	logic [`TWM_BIT_W-1:0]     bit_q;
	logic [7:0]                sh_q;
	logic [1:0]                ia_q;
	logic                      rd_q;
	logic                      rdir_q;
	logic                      ack_drv_q;
	logic                      stop_pend_q;
	logic                      scl_m_q;
	logic                      scl_s_q;
	logic                      sda_m_q;
	logic                      sda_s_q;
	logic [7:0]                fifo_data;
	logic                      fifo_valid;
	logic                      pop;
	logic                      active;
	logic                      bit_end;
	logic                      ack_end;
	logic                      tx_ph;
	logic                      ack_evt;
	logic                      not_acknowledged_flag_evt;
	logic                      rx_land;
	logic                      rx_stall;
	logic                      sda_drv;
	logic                      sda_drv_q;
	logic [`TWM_FLG_W-1:0]     flags;

	// ****************************************
	// pin sampling and tick counts
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			scl_m_q <= serial_clock_line_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= serial_data_line_i;
			sda_s_q <= sda_m_q;
		end
	end

	// shift keeps 16 bits: 8-bit divider times at most 2^7
	assign lo_ticks = ({8'h00, clock_low_divider_i} << clock_exponent_divider_i)
		+ `TWM_MIN_TICKS;
	assign hi_ticks = ({8'h00, clock_high_divider_i} << clock_exponent_divider_i)
		+ `TWM_MIN_TICKS;

	twm_fifo #(.W(8), .D(`TWM_FIFO_DEPTH)) u_txq (
		.clk_i      (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.in_data_i  (tx_data_i),
		.in_valid_i (tx_valid_i),
		.in_ready_o (tx_ready_o),
		.out_data_o (fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop)
	);

	// ****************************************
	// bit and byte events
	// ****************************************
	assign active = master_enable_cmd_i & slave_disable_cmd_i;
	assign bit_end = (st_q == twm_pkg::ST_BIT_HIGH) && scl_s_q && (cnt_q == '0);
	assign ack_end = bit_end && (bit_q == `TWM_ACK_BIT);
	assign tx_ph = (ph_q != twm_pkg::PH_RDATA);
	assign not_acknowledged_flag_evt = ack_end & tx_ph & sda_s_q;
	assign ack_evt = ack_end & tx_ph & ~sda_s_q;
	assign rx_land = bit_end && (bit_q == `TWM_LAST_BIT) && (ph_q == twm_pkg::PH_RDATA);
	assign rx_stall = (ph_q == twm_pkg::PH_RDATA) && (bit_q == `TWM_LAST_BIT)
		&& receive_ready_flag_o;
	// data present wins over a pending STOP
	assign pop = (st_q == twm_pkg::ST_WAIT_TX) && fifo_valid;

	always_comb begin
		sda_drv = 1'b0;
		case (st_q)
			twm_pkg::ST_START_HOLD,
			twm_pkg::ST_STOP_LOW,
			twm_pkg::ST_STOP_HIGH: sda_drv = 1'b1;
			twm_pkg::ST_BIT_LOW,
			twm_pkg::ST_BIT_HIGH: begin
				if (bit_q == `TWM_ACK_BIT) begin
					sda_drv = ~tx_ph & ack_drv_q;
				end else begin
					sda_drv = tx_ph & ~sh_q[7];
				end
			end
			default: sda_drv = 1'b0;
		endcase
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q   <= twm_pkg::ST_IDLE;
			ph_q   <= twm_pkg::PH_ADDR;
			cnt_q  <= '0;
			bit_q  <= '0;
			sh_q   <= '0;
			ia_q   <= '0;
			rd_q   <= 1'b0;
			rdir_q <= 1'b0;
		end else begin
			if (cnt_q != '0 && !(st_q == twm_pkg::ST_BIT_LOW && rx_stall)) begin
				cnt_q <= cnt_q - 1'b1;
			end
			case (st_q)
				twm_pkg::ST_IDLE: begin
					// target address sampled here and again at repeated START; internal address bytes are read live, so hold both through a transfer
					if (active && (start_cmd_i ? read_direction_i
						: (fifo_valid && !read_direction_i))) begin
						rdir_q <= read_direction_i;
						ia_q   <= internal_address_size_i;
						rd_q   <= read_direction_i && (internal_address_size_i == 2'h0);
						sh_q   <= {target_device_address_i,
							read_direction_i && (internal_address_size_i == 2'h0)};
						ph_q   <= twm_pkg::PH_ADDR;
						bit_q  <= '0;
						cnt_q  <= hi_ticks;
						st_q   <= twm_pkg::ST_START_HOLD;
					end
				end
				twm_pkg::ST_START_HOLD: begin
					if (cnt_q == '0) begin
						cnt_q <= lo_ticks;
						st_q  <= twm_pkg::ST_BIT_LOW;
					end
				end
				twm_pkg::ST_BIT_LOW: begin
					if (cnt_q == '0 && !rx_stall) begin
						cnt_q <= hi_ticks;
						st_q  <= twm_pkg::ST_BIT_HIGH;
					end
				end
				twm_pkg::ST_BIT_HIGH: begin
					if (bit_end && bit_q != `TWM_ACK_BIT) begin
						sh_q  <= {sh_q[6:0], sda_s_q};
						bit_q <= bit_q + 1'b1;
						cnt_q <= lo_ticks;
						st_q  <= twm_pkg::ST_BIT_LOW;
					end else if (ack_end) begin
						bit_q <= '0;
						cnt_q <= lo_ticks;
						if (not_acknowledged_flag_evt) begin
							st_q <= twm_pkg::ST_STOP_LOW;
						end else begin
							case (ph_q)
								twm_pkg::PH_ADDR: begin
									if (rd_q) begin
										ph_q <= twm_pkg::PH_RDATA;
										st_q <= twm_pkg::ST_BIT_LOW;
									end else if (ia_q != 2'h0) begin
										ph_q <= twm_pkg::PH_INTERNAL_ADDRESS_BYTES;
										sh_q <= ia_byte(ia_q);
										st_q <= twm_pkg::ST_BIT_LOW;
									end else begin
										ph_q <= twm_pkg::PH_WDATA;
										st_q <= twm_pkg::ST_WAIT_TX;
									end
								end
								twm_pkg::PH_INTERNAL_ADDRESS_BYTES: begin
									ia_q <= ia_q - 1'b1;
									if (ia_q > 2'h1) begin
										sh_q <= ia_byte(ia_q - 2'h1);
										st_q <= twm_pkg::ST_BIT_LOW;
									end else if (rdir_q) begin
										st_q <= twm_pkg::ST_RS_LOW;
									end else begin
										ph_q <= twm_pkg::PH_WDATA;
										st_q <= twm_pkg::ST_WAIT_TX;
									end
								end
								twm_pkg::PH_WDATA: st_q <= twm_pkg::ST_WAIT_TX;
								default: begin
									// last byte left unacknowledged, then STOP
									st_q <= ack_drv_q ? twm_pkg::ST_BIT_LOW
										: twm_pkg::ST_STOP_LOW;
								end
							endcase
						end
					end
				end
				twm_pkg::ST_WAIT_TX: begin
					if (fifo_valid) begin
						sh_q  <= fifo_data;
						cnt_q <= lo_ticks;
						st_q  <= twm_pkg::ST_BIT_LOW;
					end else if (stop_pend_q) begin
						cnt_q <= lo_ticks;
						st_q  <= twm_pkg::ST_STOP_LOW;
					end
				end
				twm_pkg::ST_RS_LOW: begin
					if (cnt_q == '0) begin
						cnt_q <= hi_ticks;
						st_q  <= twm_pkg::ST_RS_HIGH;
					end
				end
				twm_pkg::ST_RS_HIGH: begin
					if (cnt_q == '0 && scl_s_q) begin
						rd_q  <= 1'b1;
						ph_q  <= twm_pkg::PH_ADDR;
						sh_q  <= {target_device_address_i, 1'b1};
						cnt_q <= hi_ticks;
						st_q  <= twm_pkg::ST_START_HOLD;
					end
				end
				twm_pkg::ST_STOP_LOW: begin
					if (cnt_q == '0) begin
						cnt_q <= hi_ticks;
						st_q  <= twm_pkg::ST_STOP_HIGH;
					end
				end
				twm_pkg::ST_STOP_HIGH: begin
					if (cnt_q == '0 && scl_s_q) begin
						cnt_q <= hi_ticks;
						st_q  <= twm_pkg::ST_STOP_REL;
					end
				end
				twm_pkg::ST_STOP_REL: begin
					// bus-free time before a new START
					if (cnt_q == '0) begin
						st_q <= twm_pkg::ST_IDLE;
					end
				end
				default: st_q <= twm_pkg::ST_IDLE;
			endcase
		end
	end

	function automatic logic [7:0] ia_byte(input logic [1:0] n);
		case (n)
			2'h3: ia_byte = internal_address_bytes_i[23:16];
			2'h2: ia_byte = internal_address_bytes_i[15:8];
			default: ia_byte = internal_address_bytes_i[7:0];
		endcase
	endfunction : ia_byte

	// ****************************************
	// STOP request and acknowledge choice
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stop_pend_q <= 1'b0;
			ack_drv_q   <= 1'b0;
		end else begin
			if (st_q == twm_pkg::ST_IDLE) begin
				stop_pend_q <= stop_cmd_i;
			end else if (stop_cmd_i) begin
				stop_pend_q <= 1'b1;
			end
			if (rx_land) begin
				ack_drv_q <= ~stop_pend_q;
			end
		end
	end

	// ****************************************
	// status flags, set wins over clear
	// ****************************************
	assign flags = {not_acknowledged_flag_o, receive_ready_flag_o, transmit_ready_flag_o};

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			transmit_ready_flag_o   <= 1'b0;
			receive_ready_flag_o    <= 1'b0;
			not_acknowledged_flag_o <= 1'b0;
			rx_data_o               <= '0;
			irq_o                   <= 1'b0;
		end else begin
			if (ack_evt) begin
				transmit_ready_flag_o <= 1'b1;
			end else if (tx_valid_i && tx_ready_o) begin
				transmit_ready_flag_o <= 1'b0;
			end
			if (rx_land) begin
				rx_data_o            <= {sh_q[6:0], sda_s_q};
				receive_ready_flag_o <= 1'b1;
			end else if (rx_read_i) begin
				receive_ready_flag_o <= 1'b0;
			end
			if (not_acknowledged_flag_evt) begin
				not_acknowledged_flag_o <= 1'b1;
			end else if (status_read_i) begin
				not_acknowledged_flag_o <= 1'b0;
			end
			irq_o <= |(flags & int_enable_i);
		end
	end

	// ****************************************
	// open-drain pins: pull low or release
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_clock_line_o    <= 1'b0;
			serial_clock_line_oe_o <= 1'b0;
			serial_data_line_o     <= 1'b0;
			serial_data_line_oe_o  <= 1'b0;
			sda_drv_q              <= 1'b0;
		end else begin
			serial_clock_line_o    <= 1'b0;
			serial_data_line_o     <= 1'b0;
			serial_clock_line_oe_o <= (st_q == twm_pkg::ST_BIT_LOW)
				|| (st_q == twm_pkg::ST_WAIT_TX) || (st_q == twm_pkg::ST_RS_LOW)
				|| (st_q == twm_pkg::ST_STOP_LOW);
			// data lags the clock pin a cycle, so it never moves as clock falls
			sda_drv_q              <= sda_drv;
			serial_data_line_oe_o  <= sda_drv_q;
		end
	end
endmodule : twm_master

`default_nettype wire

// >>> verification/twm_master_assertions.sv
// Purpose: port-level checks of the two-wire master engine
// Assumes: bound to twm_master, one clock domain
// Notes:   sees top ports only; idle run length kept in helper logic
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"
module twm_chk (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  tx_valid_i,
	input  wire logic                  tx_ready_o,
	input  wire logic                  rx_read_i,
	input  wire logic                  status_read_i,
	input  wire logic [`TWM_FLG_W-1:0] int_enable_i,
	input  wire logic                  transmit_ready_flag_o,
	input  wire logic                  receive_ready_flag_o,
	input  wire logic                  not_acknowledged_flag_o,
	input  wire logic                  irq_o,
	input  wire logic                  serial_clock_line_o,
	input  wire logic                  serial_clock_line_oe_o,
	input  wire logic                  serial_data_line_o,
	input  wire logic                  serial_data_line_oe_o
);
	// ****************************************
	// helpers
	// ****************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic [7:0] idle_q;
	// saturates so a long idle bus never wraps back under the threshold
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			idle_q <= 8'h00;
		else if (serial_clock_line_oe_o || serial_data_line_oe_o)
			idle_q <= 8'h00;
		else if (idle_q != 8'hFF)
			idle_q <= idle_q + 8'h01;
	end
	sequence s_quiet;
		!serial_clock_line_oe_o && !serial_data_line_oe_o;
	endsequence
	sequence s_high_rel;
		!serial_clock_line_oe_o && $past(!serial_clock_line_oe_o);
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_pins_pull_only: assert property (!serial_clock_line_o && !serial_data_line_o)
		else $error("pin output level not low");
	a_start_data_first: assert property (idle_q > 8'h28 && serial_clock_line_oe_o |-> serial_data_line_oe_o)
		else $error("clock pulled before data at start");
	a_stop_then_idle: assert property (s_high_rel and $fell(serial_data_line_oe_o) |-> s_quiet [*8])
		else $error("data rose in high phase without bus release");
	a_not_acknowledged_flag_sends_stop: assert property ($rose(not_acknowledged_flag_o) |-> ##[0:200] s_quiet [*8])
		else $error("no stop after not-acknowledge");
	a_status_clears: assert property (status_read_i |=> !not_acknowledged_flag_o || $rose(not_acknowledged_flag_o))
		else $error("status read left flag set");
	a_irq_follows: assert property (1'b1 |=> irq_o == |($past({not_acknowledged_flag_o, receive_ready_flag_o, transmit_ready_flag_o}) & $past(int_enable_i)))
		else $error("interrupt line not matching enabled flags");
	a_push_clears_tx: assert property (tx_valid_i && tx_ready_o |=> !transmit_ready_flag_o)
		else $error("write left transmit flag set");
	a_read_clears_rx: assert property (rx_read_i && receive_ready_flag_o |=> !receive_ready_flag_o)
		else $error("read left receive flag set");
endmodule : twm_chk
`default_nettype wire

// >>> verification/twm_slave_model.sv
// Purpose: behavioural slave on the open-drain two-wire bus
// Assumes: lines resolved with pull-ups by the bench
// Notes:   logs every byte it receives; read bytes count up from rdata_i
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model #(
	parameter logic [6:0] ADDR = 7'h52
) (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       not_acknowledged_flag_data_i,
	input  wire logic [7:0] rdata_i,
	output logic            sda_oe_o
);
	logic [7:0] sh, rb;
	logic [7:0] log_q [0:63];
	logic       act, rd, first, hit, mack;
	int         bc, n, nr;
	initial begin
		sda_oe_o = 1'b0;
		act = 1'b0;
		hit = 1'b0;
		n = 0;
		nr = 0;
		bc = 0;
	end
	// start or repeated start opens a frame
	always @(negedge sda_i) if (scl_i) begin
		act = 1'b1;
		first = 1'b1;
		bc = 0;
	end
	// stop closes the frame
	always @(posedge sda_i) if (scl_i) act = 1'b0;
	// msb first, ninth pulse is the acknowledge slot
	always @(posedge scl_i) if (act) begin
		bc = bc + 1;
		if (bc <= 8) sh = {sh[6:0], sda_i};
		else mack = !sda_i;
	end
	// only pulls low or releases, never drives high
	always @(negedge scl_i) if (act) begin
		if (bc == 8) begin
			sda_oe_o = 1'b0;
			if (first || !rd) begin
				log_q[n] = sh;
				n = n + 1;
			end
			if (first) begin
				hit = (sh[7:1] == ADDR);
				rd = sh[0];
				sda_oe_o = hit;
			end else if (!rd) sda_oe_o = !not_acknowledged_flag_data_i;
		end else if (bc == 9) begin
			bc = 0;
			sda_oe_o = 1'b0;
			// first byte right after the address, each next one only after the master acknowledged
			if (rd && hit && (first || mack)) begin
				rb = rdata_i + 8'(nr);
				nr = nr + 1;
				sda_oe_o = !rb[7];
			end
			first = 1'b0;
		end else if (rd && hit && !first && bc > 0) sda_oe_o = !rb[7 - bc];
	end
endmodule : twm_slave_model
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the two-wire master engine
// Assumes: slave model at address 52h on pulled-up lines
// Notes:   dividers 2/2/0 give a bit time near 250 ns
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        sys_clk_i, rst_n_i, men, rdir, start, stop, txv, txr, rxr, srd, nkd;
	logic        txf, rxf, nkf, irq, scl_oe, sda_oe, m_oe, svd;
	logic [6:0]  addr;
	logic [1:0]  isz;
	logic [23:0] iad;
	logic [7:0]  txd, rxd, rdat;
	logic [2:0]  ien, ckd;
	wire         scl, sda;
	int          n_mismatch, n_compared, idle_n, want, b;
	assign scl = !scl_oe;
	assign sda = !(sda_oe || m_oe);
	twm_master twm_master_inst (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .master_enable_cmd_i(men),
		.slave_disable_cmd_i(svd), .target_device_address_i(addr), .read_direction_i(rdir),
		.internal_address_size_i(isz), .internal_address_bytes_i(iad),
		.clock_exponent_divider_i(ckd), .clock_high_divider_i(8'h02),
		.clock_low_divider_i(8'h02), .start_cmd_i(start), .stop_cmd_i(stop),
		.tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr), .rx_read_i(rxr),
		.rx_data_o(rxd), .status_read_i(srd), .int_enable_i(ien),
		.transmit_ready_flag_o(txf), .receive_ready_flag_o(rxf),
		.not_acknowledged_flag_o(nkf), .irq_o(irq), .serial_clock_line_i(scl),
		.serial_clock_line_o(), .serial_clock_line_oe_o(scl_oe), .serial_data_line_i(sda),
		.serial_data_line_o(), .serial_data_line_oe_o(sda_oe));
	twm_slave_model twm_slave_model_inst (
		.scl_i(scl), .sda_i(sda), .not_acknowledged_flag_data_i(nkd), .rdata_i(rdat), .sda_oe_o(m_oe));
	// ****************************************
	// shared tasks
	// ****************************************
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = !sys_clk_i;
	end
	always @(posedge sys_clk_i) idle_n <= (scl && sda) ? idle_n + 1 : 0;
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
		#2;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	function automatic logic sel(input int w);
		case (w)
			0: return txf;
			1: return rxf;
			2: return nkf;
			3: return idle_n > 30;
			default: return twm_slave_model_inst.n >= want;
		endcase
	endfunction : sel
	task automatic wait_for(input int w);
		int i;
		i = 0;
		while (sel(w) !== 1'b1 && i < 3000) begin
			tick(1);
			i++;
		end
		if (i >= 3000) begin
			n_mismatch++;
			$display("mismatch wait %0d expected 1 seen timeout", w);
			give_verdict();
		end
	endtask : wait_for
	task automatic logged(input int i, input logic [7:0] exp);
		cmp("slave log", exp, twm_slave_model_inst.log_q[i]);
	endtask : logged
	task automatic give_verdict();
		$display("compared %0d mismatch %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_fill_write();
		int k;
		men = 1'b0;
		k = 0;
		while (txr === 1'b1 && k < 20) begin
			txd = 8'(k);
			txv = 1'b1;
			tick(1);
			k++;
		end
		txv = 1'b0;
		cmp("fifo accepted", 8'h10, 8'(k));
		men = 1'b1;
		want = 17;
		wait_for(4);
		wait_for(0);
		tick(40);
		cmp("clock held low", 8'h00, {7'h00, scl});
		cmp("tx ready", 8'h01, {7'h00, txf});
		logged(0, 8'hA4);
		for (k = 0; k < 16; k++) logged(k + 1, 8'(k));
		pulse(stop);
		wait_for(3);
	endtask : t_fill_write
	task automatic t_iaddr_write();
		b = twm_slave_model_inst.n;
		isz = 2'h3;
		iad = 24'h56_1234;
		txd = 8'h77;
		txv = 1'b1;
		tick(1);
		txv = 1'b0;
		tick(2);
		cmp("tx ready cleared", 8'h00, {7'h00, txf});
		want = b + 5;
		wait_for(4);
		wait_for(0);
		logged(b, 8'hA4);
		logged(b + 1, 8'h56);
		logged(b + 2, 8'h12);
		logged(b + 3, 8'h34);
		logged(b + 4, 8'h77);
		pulse(stop);
		wait_for(3);
	endtask : t_iaddr_write
	task automatic t_not_acknowledged_flag();
		isz = 2'h0;
		nkd = 1'b1;
		ien = 3'h4;
		svd = 1'b0;
		txd = 8'h5A;
		txv = 1'b1;
		tick(1);
		txv = 1'b0;
		tick(20);
		cmp("held while slave on", 8'h00, {6'h00, scl_oe, sda_oe});
		svd = 1'b1;
		wait_for(2);
		wait_for(3);
		cmp("irq on not_acknowledged_flag", 8'h01, {7'h00, irq});
		pulse(srd);
		tick(1);
		cmp("not_acknowledged_flag cleared", 8'h00, {7'h00, nkf});
		nkd = 1'b0;
		addr = 7'h11;
		rdir = 1'b1;
		pulse(start);
		wait_for(2);
		wait_for(3);
		pulse(srd);
		b = twm_slave_model_inst.n;
		addr = 7'h79;
		isz = 2'h1;
		iad = 24'h00_005C;
		pulse(start);
		wait_for(2);
		wait_for(3);
		logged(b, 8'hF2);
		pulse(srd);
		isz = 2'h0;
		addr = 7'h52;
		ien = 3'h0;
	endtask : t_not_acknowledged_flag
	task automatic t_read2();
		b = twm_slave_model_inst.n;
		rdat = 8'hC0;
		twm_slave_model_inst.nr = 0;
		pulse(start);
		wait_for(1);
		cmp("rx byte 1", 8'hC0, rxd);
		logged(b, 8'hA5);
		pulse(stop);
		tick(150);
		cmp("stretch", 8'h00, {7'h00, scl});
		tick(20);
		cmp("stretch", 8'h00, {7'h00, scl});
		pulse(rxr);
		cmp("rx cleared", 8'h00, {7'h00, rxf});
		wait_for(1);
		cmp("rx byte 2", 8'hC1, rxd);
		pulse(rxr);
		wait_for(3);
		cmp("last nacked", 8'h00, {7'h00, twm_slave_model_inst.mack});
	endtask : t_read2
	task automatic t_read1_iaddr();
		int k;
		b = twm_slave_model_inst.n;
		isz = 2'h1;
		ckd = 3'h1;
		iad = 24'h00_009C;
		rdat = 8'h40;
		twm_slave_model_inst.nr = 0;
		start = 1'b1;
		stop = 1'b1;
		tick(1);
		start = 1'b0;
		stop = 1'b0;
		k = 0;
		while (scl !== 1'b0 && k < 200) begin
			tick(1);
			k++;
		end
		k = 0;
		while (scl === 1'b0 && k < 50) begin
			tick(1);
			k++;
		end
		// low phase: (2 << 1) + 2 ticks plus the cycle at zero count
		cmp("low phase cycles", 8'h07, 8'(k));
		wait_for(1);
		cmp("rx single", 8'h40, rxd);
		logged(b, 8'hA4);
		logged(b + 1, 8'h9C);
		logged(b + 2, 8'hA5);
		wait_for(3);
		cmp("single nacked", 8'h00, {7'h00, twm_slave_model_inst.mack});
		pulse(rxr);
	endtask : t_read1_iaddr
	initial begin
		{rst_n_i, men, rdir, start, stop, txv, rxr, srd, nkd} = 9'h000;
		{addr, isz, iad, txd, rdat, ien} = {7'h52, 2'h0, 24'h00_0000, 8'h00, 8'h00, 3'h0};
		n_mismatch = 0;
		n_compared = 0;
		svd = 1'b1;
		ckd = 3'h0;
		tick(6);
		rst_n_i = 1'b1;
		tick(2);
		cmp("reset flags", 8'h00, {5'h00, nkf, rxf, txf});
		cmp("reset pins", 8'h00, {6'h00, scl_oe, sda_oe});
		cmp("reset rx", 8'h00, rxd);
		t_fill_write();
		t_iaddr_write();
		t_not_acknowledged_flag();
		t_read2();
		t_read1_iaddr();
		give_verdict();
	end
endmodule : tb_top
bind twm_master twm_chk twm_chk_inst (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_i),
	.tx_ready_o(tx_ready_o), .rx_read_i(rx_read_i), .status_read_i(status_read_i),
	.int_enable_i(int_enable_i), .transmit_ready_flag_o(transmit_ready_flag_o),
	.receive_ready_flag_o(receive_ready_flag_o),
	.not_acknowledged_flag_o(not_acknowledged_flag_o), .irq_o(irq_o),
	.serial_clock_line_o(serial_clock_line_o), .serial_clock_line_oe_o(serial_clock_line_oe_o),
	.serial_data_line_o(serial_data_line_o), .serial_data_line_oe_o(serial_data_line_oe_o));
`default_nettype wire
